// ===== rtl/mcu_interrupt_gating_unit.sv
// Interrupt gating unit: request flags, enables, vectoring and return
// Notes on behaviour
// R1: Seventeen request sources, each with its own flag bit.
// R2: Flags set on their event regardless of any enable bit.
// R3: Global enable at control bit 7 allows enabled requests, blocks all when clear.
// R4: Global enable plus a flagged and enabled source takes the interrupt.
// R5: Reset clears the global enable.
// R6: Taking clears global enable, pushes return address, loads vector 0004h.
// R7: Return-from-interrupt pops the return address and sets global enable.
// R8: Pin, port change and timer flags and enables live in the control register.
// R9: Peripheral flags and enables in own registers, gated by the group enable.
// R10: External events reach the vector in three or four instruction cycles.
// R11: Software clears serviced flags before enabling again, else recursion.
// R12: Hardware never clears a flag; only a software write of zero does.
//
// Local design decisions: strobed register access and the register addresses.
`default_nettype none
module mcu_interrupt_gating_unit #(
  parameter int PERIPH_SRC = irq_pkg::PERIPH_SRC_DEF,
  parameter int PORT_W = irq_pkg::PORT_W_DEF,
  parameter int STACK_DEPTH = irq_pkg::STACK_DEPTH_DEF
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [irq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [irq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [irq_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_external_irq_pin,
  input wire logic [PORT_W-1:0] i_port_pins,
  input wire logic i_timer_zero_ovf,
  input wire logic [PERIPH_SRC-1:0] i_periph_event,
  input wire logic [irq_pkg::PC_W-1:0] i_pc,
  input wire logic i_call,
  input wire logic i_return,
  input wire logic i_return_from_irq_instr,
  output logic o_pc_load,
  output logic [irq_pkg::PC_W-1:0] o_pc_value,
  output logic o_vector_taken,
  output logic o_global_irq_enable,
  output logic o_irq
);
  import irq_pkg::*;

  // Instruction cycle divider
  logic [Q_W-1:0] q_reg;
  wire icyc = (q_reg == Q_LAST);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_reg + Q_ONE;
    end
  end

  // Pin synchronisers and change detectors
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_prev_reg;
  logic [PORT_W-1:0] port_s1_reg;
  logic [PORT_W-1:0] port_s2_reg;
  logic [PORT_W-1:0] port_prev_reg;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      port_s1_reg <= '0;
      port_s2_reg <= '0;
      port_prev_reg <= '0;
    end else begin
      pin_s1_reg <= i_external_irq_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      port_s1_reg <= i_port_pins;
      port_s2_reg <= port_s1_reg;
      port_prev_reg <= port_s2_reg;
    end
  end

  // Registers
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] ctrl_next;
  logic [PERIPH_SRC-1:0] pflag_reg;
  logic [PERIPH_SRC-1:0] pflag_next;
  logic [PERIPH_SRC-1:0] pen_reg;
  logic [PERIPH_SRC-1:0] pen_next;
  logic [DATA_W-1:0] opt_reg;
  logic [EVT_W-1:0] evt_reg;
  logic [EVT_W-1:0] evt_next;
  logic [EVT_W-1:0] mask_reg;
  logic [EVT_W-1:0] mask_next;
  logic [DATA_W-1:0] taken_src_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic pc_load_reg;
  logic [PC_W-1:0] pc_value_reg;
  logic vector_reg;
  logic irq_reg;
  take_state_t st_reg;
  take_state_t st_next;

  // Write decode
  wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
  wire wr_pf_lo = i_wr && (i_addr == REG_PFLAG_LO);
  wire wr_pf_hi = i_wr && (i_addr == REG_PFLAG_HI);
  wire wr_pe_lo = i_wr && (i_addr == REG_PEN_LO);
  wire wr_pe_hi = i_wr && (i_addr == REG_PEN_HI);
  wire wr_opt = i_wr && (i_addr == REG_OPTION);
  wire wr_evt = i_wr && (i_addr == REG_EVT_STATUS);
  wire wr_mask = i_wr && (i_addr == REG_EVT_MASK);

  // Source events
  wire edge_rise = opt_reg[OPT_EDGE_BIT];
  wire pin_rise = pin_s2_reg & ~pin_prev_reg;
  wire pin_fall = ~pin_s2_reg & pin_prev_reg;
  wire pin_event = edge_rise ? pin_rise : pin_fall;
  wire port_event = |(port_s2_reg ^ port_prev_reg);

  wire [DATA_W-1:0] ctrl_set =
    (DATA_W'(i_timer_zero_ovf) << TMR_IF_BIT) |
    (DATA_W'(pin_event) << PIN_IF_BIT) |
    (DATA_W'(port_event) << PORT_IF_BIT); // see R8

  // Gating
  wire tmr_hit = ctrl_reg[TMR_IF_BIT] & ctrl_reg[TMR_IE_BIT];
  wire pin_hit = ctrl_reg[PIN_IF_BIT] & ctrl_reg[PIN_IE_BIT];
  wire port_hit = ctrl_reg[PORT_IF_BIT] & ctrl_reg[PORT_IE_BIT];
  wire core_hit = tmr_hit | pin_hit | port_hit;
  wire [PERIPH_SRC-1:0] periph_armed = pflag_reg & pen_reg;
  wire periph_hit = ctrl_reg[PERIPH_GROUP_IRQ_ENABLE_BIT] & (|periph_armed); // see R9
  wire any_hit = core_hit | periph_hit;
  wire pending = ctrl_reg[GIE_BIT] & any_hit; // see R3

  // Stack traffic from the core has priority; entry waits for the next instruction cycle, or restarts from ST_IDLE after return-from-interrupt
  wire return_from_irq_instr = i_return_from_irq_instr;
  wire blocked = i_call | i_return | return_from_irq_instr;
  wire take = icyc & (st_reg == ST_DUE) & pending & ~blocked; // see R4

  // Entry pipeline: counts instruction boundaries while a request stands
  always_comb begin
    st_next = st_reg;
    if (return_from_irq_instr || !pending) begin
      st_next = ST_IDLE;
    end else if (icyc) begin
      unique case (st_reg)
        ST_IDLE: begin
          st_next = ST_SEEN;
        end
        ST_SEEN: begin
          st_next = ST_DUE; // see R10
        end
        ST_DUE: begin
          st_next = blocked ? ST_DUE : ST_IDLE;
        end
      endcase
    end
  end

  // Control register update; flag events OR in so they beat a clearing write
  wire [DATA_W-1:0] ctrl_base = wr_ctrl ? i_wdata : ctrl_reg; // see R12
  wire [DATA_W-1:0] ctrl_mix = ctrl_base | ctrl_set; // see R2

  always_comb begin
    ctrl_next = ctrl_mix;
    if (take) begin
      ctrl_next = ctrl_mix & ~GIE_MASK; // see R6
    end else if (return_from_irq_instr) begin
      ctrl_next = ctrl_mix | GIE_MASK; // see R7
    end
  end

  // Peripheral flags and enables across two byte addresses
  wire [PAD_W-1:0] pflag_wr = byte_merge(PAD_W'(pflag_reg), i_wdata, wr_pf_lo, wr_pf_hi);
  wire [PAD_W-1:0] pen_wr = byte_merge(PAD_W'(pen_reg), i_wdata, wr_pe_lo, wr_pe_hi);

  assign pflag_next = pflag_wr[PERIPH_SRC-1:0] | i_periph_event; // see R1
  assign pen_next = pen_wr[PERIPH_SRC-1:0];

  // Return-address stack
  irq_stack_if #(.DW(PC_W), .DEPTH(STACK_DEPTH)) stk ();

  assign stk.push = take | i_call; // see R6
  assign stk.push_data = i_pc;
  assign stk.pop = i_return | return_from_irq_instr; // see R7

  irq_return_stack #(
    .DW(PC_W),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .stk(stk.stack)
  );

  // Event status, mask and interrupt line
  // Retrigger warns that software left an enabled flag set on return
  wire [EVT_W-1:0] evt_set =
    (EVT_W'(take) << EVT_TAKEN) |
    (EVT_W'(return_from_irq_instr) << EVT_RETURN) |
    (EVT_W'(stk.overflow) << EVT_OVF) |
    (EVT_W'(stk.underflow) << EVT_UNF) |
    (EVT_W'(return_from_irq_instr & any_hit) << EVT_RETRIG); // see R11
  wire [EVT_W-1:0] evt_kept = wr_evt ? (evt_reg & ~i_wdata[EVT_W-1:0]) : evt_reg;

  assign evt_next = evt_kept | evt_set;
  assign mask_next = wr_mask ? i_wdata[EVT_W-1:0] : mask_reg;

  // Snapshot of which groups requested at the moment of entry
  wire [DATA_W-1:0] taken_snap =
    (DATA_W'(tmr_hit) << TMR_IF_BIT) |
    (DATA_W'(pin_hit) << PIN_IF_BIT) |
    (DATA_W'(port_hit) << PORT_IF_BIT) |
    (DATA_W'(periph_hit) << PERIPH_GROUP_IRQ_ENABLE_BIT);

  // Read selection; unmapped offsets read zero
  wire [PAD_W-1:0] pflag_pad = PAD_W'(pflag_reg);
  wire [PAD_W-1:0] pen_pad = PAD_W'(pen_reg);
  wire [DATA_W-1:0] rd_sel =
    (i_addr == REG_CTRL) ? ctrl_reg :
    (i_addr == REG_PFLAG_LO) ? pflag_pad[DATA_W-1:0] :
    (i_addr == REG_PFLAG_HI) ? pflag_pad[PAD_W-1:DATA_W] :
    (i_addr == REG_PEN_LO) ? pen_pad[DATA_W-1:0] :
    (i_addr == REG_PEN_HI) ? pen_pad[PAD_W-1:DATA_W] :
    (i_addr == REG_OPTION) ? opt_reg :
    (i_addr == REG_EVT_STATUS) ? DATA_W'(evt_reg) :
    (i_addr == REG_EVT_MASK) ? DATA_W'(mask_reg) :
    (i_addr == REG_STACK_DEPTH) ? DATA_W'(stk.depth) :
    (i_addr == REG_TAKEN_SRC) ? taken_src_reg :
    '0;

  wire [PC_W-1:0] pc_sel = take ? IRQ_VECTOR : stk.top_data; // see R6

  // Control and status state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= CTRL_RST; // see R5
      pflag_reg <= '0;
      pen_reg <= '0;
      opt_reg <= OPT_RST;
      evt_reg <= '0;
      mask_reg <= '0;
      st_reg <= ST_IDLE;
    end else begin
      ctrl_reg <= ctrl_next;
      pflag_reg <= pflag_next;
      pen_reg <= pen_next;
      opt_reg <= wr_opt ? i_wdata : opt_reg;
      evt_reg <= evt_next;
      mask_reg <= mask_next;
      st_reg <= st_next;
    end
  end

  // Entry snapshot holds until the next entry
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      taken_src_reg <= '0;
    end else if (take) begin
      taken_src_reg <= taken_snap;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= i_rd ? rd_sel : '0;
    end
  end

  // Core-facing strobes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc_load_reg <= 1'b0;
      pc_value_reg <= '0;
      vector_reg <= 1'b0;
    end else begin
      pc_load_reg <= take | stk.pop;
      pc_value_reg <= (take | stk.pop) ? pc_sel : pc_value_reg;
      vector_reg <= take;
    end
  end

  // Interrupt line follows the next state so it tracks status exactly
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_next & mask_next);
    end
  end

  assign o_rdata = rdata_reg;
  assign o_pc_load = pc_load_reg;
  assign o_pc_value = pc_value_reg;
  assign o_vector_taken = vector_reg;
  assign o_global_irq_enable = ctrl_reg[GIE_BIT];
  assign o_irq = irq_reg;

endmodule : mcu_interrupt_gating_unit
`default_nettype wire

// ===== common/irq_pkg.sv
// Shared constants and helpers of the interrupt gating unit
`default_nettype none
package irq_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int PAD_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PFLAG_LO = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PFLAG_HI = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PEN_LO = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PEN_HI = 4'h4;
  localparam logic [ADDR_W-1:0] REG_OPTION = 4'h5;
  localparam logic [ADDR_W-1:0] REG_EVT_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] REG_EVT_MASK = 4'h7;
  localparam logic [ADDR_W-1:0] REG_STACK_DEPTH = 4'h8;
  localparam logic [ADDR_W-1:0] REG_TAKEN_SRC = 4'h9;

  // Control register fields
  localparam int GIE_BIT = 7;
  localparam int PERIPH_GROUP_IRQ_ENABLE_BIT = 6;
  localparam int TMR_IE_BIT = 5;
  localparam int PIN_IE_BIT = 4;
  localparam int PORT_IE_BIT = 3;
  localparam int TMR_IF_BIT = 2;
  localparam int PIN_IF_BIT = 1;
  localparam int PORT_IF_BIT = 0;
  localparam logic [DATA_W-1:0] GIE_MASK = 8'h01 << GIE_BIT;
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

  // Option register: bit set selects rising edge on the external pin
  localparam int OPT_EDGE_BIT = 0;
  localparam logic [DATA_W-1:0] OPT_RST = 8'h01;

  // Event status bits
  localparam int EVT_W = 5;
  localparam int EVT_TAKEN = 0;
  localparam int EVT_RETURN = 1;
  localparam int EVT_OVF = 2;
  localparam int EVT_UNF = 3;
  localparam int EVT_RETRIG = 4;

  localparam int TOTAL_SRC = 17;
  localparam int CORE_SRC = 3;
  localparam int PERIPH_SRC_DEF = TOTAL_SRC - CORE_SRC;
  localparam int PORT_W_DEF = 4;
  localparam int STACK_DEPTH_DEF = 8;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

  // Four clocks make one instruction cycle
  localparam int Q_W = 2;
  localparam logic [Q_W-1:0] Q_LAST = 2'h3;
  localparam logic [Q_W-1:0] Q_ONE = 2'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_SEEN, ST_DUE} take_state_t;

  function automatic logic [PAD_W-1:0] byte_merge(
    input logic [PAD_W-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic sel_lo,
    input logic sel_hi
  );
    logic [PAD_W-1:0] res;
    res = old_val;
    if (sel_lo) begin
      res[DATA_W-1:0] = wdata;
    end
    if (sel_hi) begin
      res[PAD_W-1:DATA_W] = wdata;
    end
    return res;
  endfunction : byte_merge

endpackage : irq_pkg
`default_nettype wire

// ===== common/irq_stack_if.sv
// Link between the gating logic and its return-address stack
`default_nettype none
interface irq_stack_if #(
  parameter int DW = irq_pkg::PC_W,
  parameter int DEPTH = irq_pkg::STACK_DEPTH_DEF
);
  logic push;
  logic pop;
  logic [DW-1:0] push_data;
  logic [DW-1:0] top_data;
  logic overflow;
  logic underflow;
  logic [$clog2(DEPTH):0] depth;

  modport owner (
    output push, pop, push_data,
    input top_data, overflow, underflow, depth
  );
  modport stack (
    input push, pop, push_data,
    output top_data, overflow, underflow, depth
  );
endinterface : irq_stack_if
`default_nettype wire

// ===== rtl/irq_return_stack.sv
// Circular return-address stack shared by calls and interrupt entry
`default_nettype none
module irq_return_stack #(
  parameter int DW = irq_pkg::PC_W,
  parameter int DEPTH = irq_pkg::STACK_DEPTH_DEF
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  irq_stack_if.stack stk
);
  import irq_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

  logic [DW-1:0] mem [DEPTH];
  logic [PW-1:0] sp_reg;
  logic [PW:0] cnt_reg;

  wire full = (cnt_reg == FULL_CNT);
  wire empty = (cnt_reg == '0);
  wire [PW-1:0] top_idx = sp_reg - PW'(1);

  assign stk.top_data = mem[top_idx];
  assign stk.overflow = stk.push & full;
  assign stk.underflow = stk.pop & empty;
  assign stk.depth = cnt_reg;

  // Overflow wraps and overwrites the oldest entry; no refusal
  always_ff @(posedge i_clk) begin
    if (stk.push) begin
      mem[sp_reg] <= stk.push_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sp_reg <= '0;
      cnt_reg <= '0;
    end else if (stk.push) begin
      sp_reg <= sp_reg + PW'(1);
      cnt_reg <= full ? cnt_reg : cnt_reg + (PW + 1)'(1);
    end else if (stk.pop) begin
      sp_reg <= top_idx;
      cnt_reg <= empty ? cnt_reg : cnt_reg - (PW + 1)'(1);
    end
  end

endmodule : irq_return_stack
`default_nettype wire

// ===== test/irq_gate_props.sv
// Concurrent checks on the interrupt gating unit ports
`default_nettype none
module irq_gate_props (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [irq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [irq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [irq_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_return,
  input wire logic i_return_from_irq_instr,
  input wire logic o_pc_load,
  input wire logic [irq_pkg::PC_W-1:0] o_pc_value,
  input wire logic o_vector_taken,
  input wire logic o_global_irq_enable
);
  import irq_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_vector_value: assert property (o_vector_taken |-> o_pc_load && o_pc_value == IRQ_VECTOR)
    else $error("entry without vector load");
  a_entry_gie_off: assert property (o_vector_taken |-> !o_global_irq_enable && $past(o_global_irq_enable))
    else $error("entry gie state wrong");
  a_return_from_irq_instr_gie_on: assert property (i_return_from_irq_instr |=> o_global_irq_enable && o_pc_load && !o_vector_taken)
    else $error("return did not restore gie");
  a_entry_spacing: assert property (o_vector_taken |=> !o_vector_taken [*8])
    else $error("entries too close");
  a_reset_gie_off: assert property ($rose(i_arst_n) |-> !o_global_irq_enable)
    else $error("gie set after reset");
  a_gie_readback: assert property ($past(i_rd) && $past(i_addr) == REG_CTRL |-> o_rdata[GIE_BIT] == $past(o_global_irq_enable))
    else $error("gie not at control bit 7");
  a_load_cause: assert property (o_pc_load |-> o_vector_taken || $past(i_return || i_return_from_irq_instr))
    else $error("pc load without cause");
  a_gie_rise_cause: assert property ($rose(o_global_irq_enable) |->
    $past(i_return_from_irq_instr) || $past(i_wr && i_addr == REG_CTRL && i_wdata[GIE_BIT]))
    else $error("gie rose without cause");
  a_gie_fall_cause: assert property ($fell(o_global_irq_enable) |->
    o_vector_taken || $past(i_wr && i_addr == REG_CTRL && !i_wdata[GIE_BIT]))
    else $error("gie fell without cause");
endmodule : irq_gate_props
`default_nettype wire

// ===== test/core_seq_model.sv
// Behavioural core sequencer on the far side of the unit
`default_nettype none
module core_seq_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_op,
  input wire logic i_pc_load,
  input wire logic [12:0] i_pc_value,
  input wire logic i_vector_taken,
  output logic [12:0] o_pc,
  output logic o_call,
  output logic o_return,
  output logic o_return_from_irq_instr,
  output logic [12:0] o_saved_pc
);
  logic [12:0] last_pc;
  // Shadow of the most recent return address the unit should hold
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pc <= 13'h0020;
      last_pc <= 13'h0000;
      o_saved_pc <= 13'h0000;
      o_call <= 1'b0;
      o_return <= 1'b0;
      o_return_from_irq_instr <= 1'b0;
    end else begin
      last_pc <= o_pc;
      o_pc <= i_pc_load ? i_pc_value : o_pc + 13'h0001;
      if (o_call) begin
        o_saved_pc <= o_pc;
      end else if (i_vector_taken) begin
        o_saved_pc <= last_pc;
      end
      o_call <= (i_op == 2'h1);
      o_return <= (i_op == 2'h2);
      o_return_from_irq_instr <= (i_op == 2'h3);
    end
  end
endmodule : core_seq_model
`default_nettype wire

// ===== test/mcu_interrupt_gating_unit_bench.sv
// Self-checking bench for the interrupt gating unit
`default_nettype none
module mcu_interrupt_gating_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_pkg::*;
  logic clk, arst_n, wr, rd, pin, tmr, call, ret, return_from_irq_instr, pc_load, taken, global_irq_enable, irq;
  logic [3:0] addr, port;
  logic [7:0] wdata, rdata, d, ie, fl;
  logic [13:0] pev, ev;
  logic [15:0] pm;
  logic [12:0] pc, pcv, saved;
  logic [1:0] op;
  int fails, cmp_count, seed, n, tcnt;

  mcu_interrupt_gating_unit u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_external_irq_pin(pin), .i_port_pins(port),
    .i_timer_zero_ovf(tmr), .i_periph_event(pev), .i_pc(pc), .i_call(call), .i_return(ret),
    .i_return_from_irq_instr(return_from_irq_instr), .o_pc_load(pc_load), .o_pc_value(pcv), .o_vector_taken(taken),
    .o_global_irq_enable(global_irq_enable), .o_irq(irq));
  core_seq_model u_core (.i_clk(clk), .i_arst_n(arst_n), .i_op(op), .i_pc_load(pc_load), .i_pc_value(pcv),
    .i_vector_taken(taken), .o_pc(pc), .o_call(call), .o_return(ret), .o_return_from_irq_instr(return_from_irq_instr), .o_saved_pc(saved));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (taken === 1'b1) tcnt <= tcnt + 1;

  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task core_op(input logic [1:0] o);
    @(posedge clk);
    op <= o;
    @(posedge clk);
    op <= 2'h0;
    @(posedge clk);
    #1;
  endtask : core_op
  task automatic wait_take(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (taken !== 1'b1 && c < 40);
  endtask : wait_take
  // Source 0 port change, 1 external pin, 2 timer overflow
  task fire(input int s);
    @(posedge clk);
    if (s == 0) port <= port ^ (4'h1 << ($unsigned($random(seed)) % 4));
    else if (s == 1) pin <= 1'b1;
    else tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
  endtask : fire

  initial begin
    seed = 32'h9cf8cbc6;
    {arst_n, wr, rd, pin, tmr, addr, port, wdata, pev, op} = '0;
    fails = 0;
    cmp_count = 0;
    tcnt = 0;
    cyc(8);
    @(posedge clk) arst_n <= 1'b1;
    rd_reg(REG_CTRL); chk("ctrl_rst", CTRL_RST, d);
    rd_reg(REG_OPTION); chk("opt_rst", OPT_RST, d);
    rd_reg(4'hf); chk("unmapped", 8'h00, d);
    wr_reg(REG_EVT_MASK, 8'h03);
    for (int s = 0; s < 3; s++) begin
      ie = 8'h08 << s;
      fl = 8'h01 << s;
      wr_reg(REG_CTRL, ie);
      n = tcnt;
      fire(s);
      cyc(30); chk("no_take", n, tcnt);
      rd_reg(REG_CTRL); chk("flag_gie_off", ie | fl, d);
      wr_reg(REG_CTRL, ie);
      @(posedge clk) pin <= 1'b0;
      cyc(5);
      wr_reg(REG_CTRL, GIE_MASK | ie);
      fire(s);
      wait_take(n);
      n++;
      if (s < 2) chk("latency", 1, n >= 11 && n <= 17);
      else chk("take_timer", 1, n <= 16);
      chk("vector", IRQ_VECTOR, pcv);
      chk("gie_entry", 0, global_irq_enable);
      rd_reg(REG_CTRL); chk("flag_kept", ie | fl, d);
      rd_reg(REG_TAKEN_SRC); chk("taken_src", fl, d);
      wr_reg(REG_CTRL, ie);
      core_op(2'h3);
      chk("gie_ret", 1, global_irq_enable); chk("ret_pc", saved, pcv);
      wr_reg(REG_CTRL, 8'h00);
    end
    chk("irq_out", 1, irq);
    rd_reg(REG_EVT_STATUS); chk("evt", 8'h03, d & 8'h03);
    wr_reg(REG_EVT_STATUS, 8'hff);
    cyc(2); chk("irq_clr", 0, irq);
    core_op(2'h1);
    cyc(3);
    core_op(2'h2); chk("call_ret", saved, pcv);
    for (int k = 0; k < 4; k++) begin
      pm = 16'h0001 << ($unsigned($random(seed)) % 14);
      wr_reg(REG_PEN_LO, pm[7:0]);
      wr_reg(REG_PEN_HI, pm[15:8]);
      wr_reg(REG_CTRL, GIE_MASK);
      ev = pm[13:0] | 14'($random(seed));
      @(posedge clk) pev <= ev;
      @(posedge clk) pev <= 14'h0000;
      n = tcnt;
      cyc(30); chk("no_group", n, tcnt);
      rd_reg(REG_PFLAG_LO); chk("pflag_lo", ev[7:0], d);
      wr_reg(REG_CTRL, GIE_MASK | 8'h40);
      wait_take(n); chk("group_take", 1, n <= 16);
      rd_reg(REG_PFLAG_HI); chk("pflag_hi", {2'b00, ev[13:8]}, d);
      wr_reg(REG_PFLAG_LO, 8'h00);
      wr_reg(REG_PFLAG_HI, 8'h00);
      wr_reg(REG_CTRL, 8'h00);
    end
    // Four group entries were never returned from
    rd_reg(REG_STACK_DEPTH); chk("stack_depth", 8'h04, d);
    wr_reg(REG_CTRL, GIE_MASK);
    @(posedge clk) arst_n <= 1'b0;
    cyc(3);
    @(posedge clk) arst_n <= 1'b1;
    @(posedge clk) #1 chk("gie_reset", 0, global_irq_enable);
    wrap_up;
  end
  // Whole run is near five hundred cycles
  initial begin
    #1000000;
    fails++;
    wrap_up;
  end
endmodule : mcu_interrupt_gating_unit_bench

bind mcu_interrupt_gating_unit irq_gate_props u_props (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_return(i_return),
  .i_return_from_irq_instr(i_return_from_irq_instr), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
  .o_vector_taken(o_vector_taken), .o_global_irq_enable(o_global_irq_enable));
`default_nettype wire
